// file: fwe_defines.vh
`ifndef FWE_DEFINES_VH
`define FWE_DEFINES_VH
// command codes on the data pins
`define FWE_CMD_READ      8'h00
`define FWE_CMD_ERASE     8'h20
`define FWE_CMD_PROGRAM   8'h40
`define FWE_CMD_STATUS    8'h71
// status return byte field positions
`define FWE_ST_ABNORMAL   7
`define FWE_ST_CMD_ERR    6
`define FWE_ST_PROG_ERR   5
`define FWE_ST_ERASE_ERR  4
`define FWE_ST_COUNT_ERR  1
`define FWE_ST_ADDR_ERR   0
`define FWE_STATUS_RESET  8'h00
// polling flag positions
`define FWE_POLL_DONE     7
`define FWE_POLL_RESULT   6
// times, and clock rate in khz
`define FWE_CLK_KHZ       100000
`define FWE_OSC_MS        20
`define FWE_SETUP_MS      10
`define FWE_ERASE_MIN_MS  100
`define FWE_ERASE_MAX_MS  40000
`define FWE_POLL_WAIT_MS  1
`define FWE_PROG_BYTES    128
`endif

// file: fwe_sync.v
`timescale 1ns/1ns
// two-stage synchroniser for pin inputs
module fwe_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             clock_in,
   input  wire             rst_n_in,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second; both clear to zero, the idle level of the inverted strobe and hold pins
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_q   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// file: fwe_timer.v
`timescale 1ns/1ns
// millisecond tick divider plus a loadable millisecond down-counter
module fwe_timer
#(
   parameter TICK_CYCLES = 100000,
   parameter MS_WIDTH    = 16
)
(
   input  wire                clock_in,
   input  wire                rst_n_in,
   input  wire                load_in,
   input  wire [MS_WIDTH-1:0] load_ms_in,
   output reg                 tick_out,
   output reg                 expired_out
);
   reg [16:0]         div_q;
   reg [MS_WIDTH-1:0] ms_q;

   // one-cycle enable each millisecond; restarts with each load for exact spans
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         div_q       <= 17'h0;
         tick_out    <= 1'b0;
         ms_q        <= {MS_WIDTH{1'b0}};
         expired_out <= 1'b0;
      end
      else if (load_in)
      begin
         div_q       <= 17'h0;
         tick_out    <= 1'b0;
         ms_q        <= load_ms_in;
         expired_out <= 1'b0;
      end
      else
      begin
         tick_out <= (div_q == TICK_CYCLES[16:0] - 17'h1);
         if (div_q == TICK_CYCLES[16:0] - 17'h1)
            div_q <= 17'h0;
         else
            div_q <= div_q + 17'h1;
         if (tick_out)
         begin
            if (ms_q != {MS_WIDTH{1'b0}})
               ms_q <= ms_q - {{(MS_WIDTH-1){1'b0}}, 1'b1};
            expired_out <= (ms_q <= {{(MS_WIDTH-1){1'b0}}, 1'b1});
         end
      end
   end
endmodule

// file: fwe_writer.v
`timescale 1ns/1ns
`include "fwe_defines.vh"
// Overview of operation
// - auto-erase always clears the whole array, no partial erase
// - poll no sooner than 1 ms; erase ends 100 to 40000 ms after command
// - polling flags held until next command write, driven on chip and output enable
// - status read reports the kind of abnormal termination
// - status return code kept until a non-status command is written
// - status byte resets to zero; bits 7,6,5,4,1,0 carry error kinds
// - bit 7 polling flag shows whether the internal operation runs
// - bit 6 polling flag tells normal from abnormal completion
// - polling: 00 running, 10 abnormal, 11 normal; low six bits zero
// - command writes ignored for 20 ms stabilisation plus setup period
// - after 10 ms setup the device enters memory read mode itself
// - codes: erase 20h twice, status 71h twice, read 00h, program 40h
// - read is cs,oe low; write is cs,we low; pins float otherwise
// - after program, erase or status read, return to command wait
module fwe_writer
#(
   parameter OSC_MS       = `FWE_OSC_MS,
   parameter SETUP_MS     = `FWE_SETUP_MS,
   parameter ERASE_MS     = `FWE_ERASE_MIN_MS,
   parameter TICK_CYCLES  = `FWE_CLK_KHZ
)
(
   input  wire        clock_in,
   input  wire        rst_n_in,
   input  wire        hold_low_input_n_in,
   input  wire        chip_sel_n_in,
   input  wire        out_en_n_in,
   input  wire        write_en_n_in,
   input  wire [17:0] flash_addr_pins_in,
   input  wire [7:0]  flash_data_pins_in,
   input  wire [7:0]  mem_rdata_in,
   input  wire        erase_fail_in,
   input  wire        prog_fail_in,
   output reg  [7:0]  flash_data_pins_out,
   output reg         flash_data_pins_oe_out,
   output reg  [17:0] mem_addr_out,
   output reg         mem_read_out,
   output reg         erase_start_out,
   output reg         prog_write_out,
   output reg  [7:0]  prog_data_out,
   output reg         busy_out,
   output reg         cmd_ready_out
);
   // device states
   localparam ST_STARTUP = 3'h0;
   localparam ST_SETUP   = 3'h1;
   localparam ST_WAIT    = 3'h2;
   localparam ST_READ    = 3'h3;
   localparam ST_ERASE   = 3'h4;
   localparam ST_PROG    = 3'h5;
   localparam ST_SHOW    = 3'h6;

   // what the data pins present on a read
   localparam SHOW_MEM    = 2'h0;
   localparam SHOW_POLL   = 2'h1;
   localparam SHOW_STATUS = 2'h2;

   // second-cycle expectations
   localparam EXP_NONE    = 2'h0;
   localparam EXP_ERASE   = 2'h1;
   localparam EXP_STATUS  = 2'h2;

   reg [2:0]  state_q;
   reg [1:0]  show_q;
   reg [1:0]  expect_q;
   reg [7:0]  status_q;
   reg [1:0]  poll_q;
   reg [7:0]  prog_cnt_q;
   reg        we_prev_q;
   reg        tmr_load_q;
   reg [15:0] tmr_ms_q;
   wire       tmr_expired;
   wire       cs_n_s;
   wire       oe_n_s;
   wire       we_n_s;
   wire       hold_n_s;
   wire [7:0] din_s;
   wire [17:0] addr_s;
   wire       rd_active;
   wire       wr_pulse;

   // all pin inputs pass two flops; strobes idle high
   fwe_sync #(.WIDTH(30)) u_sync
   (
      .clock_in   (clock_in),
      .rst_n_in   (rst_n_in),
      .async_in   ({~hold_low_input_n_in, ~chip_sel_n_in, ~out_en_n_in,
                    ~write_en_n_in, flash_addr_pins_in, flash_data_pins_in}),
      .sync_out   ({hold_n_s, cs_n_s, oe_n_s, we_n_s, addr_s, din_s})
   );

   // millisecond timer for startup and erase duration
   fwe_timer #(.TICK_CYCLES(TICK_CYCLES), .MS_WIDTH(16)) u_timer
   (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .load_in     (tmr_load_q),
      .load_ms_in  (tmr_ms_q),
      .tick_out    (),
      .expired_out (tmr_expired)
   );

   // synced strobe and hold values are inverted so reset zero means idle
   // read and write strobe decode
   assign rd_active = cs_n_s & oe_n_s & ~we_n_s;
   // a write is taken on the rising edge of write enable, data then settled
   assign wr_pulse  = we_prev_q & ~we_n_s & cs_n_s & ~oe_n_s;

   // hold-low pin acts as a second reset: it forces the startup state
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q        <= ST_STARTUP;
         show_q         <= SHOW_MEM;
         expect_q       <= EXP_NONE;
         status_q       <= `FWE_STATUS_RESET;
         poll_q         <= 2'h0;
         prog_cnt_q     <= 8'h0;
         we_prev_q      <= 1'b0;
         tmr_load_q     <= 1'b1;
         tmr_ms_q       <= OSC_MS[15:0];  // a hold pin already high still waits full startup
         erase_start_out <= 1'b0;
         prog_write_out <= 1'b0;
         prog_data_out  <= 8'h0;
         mem_addr_out   <= 18'h0;
         busy_out       <= 1'b0;
         cmd_ready_out  <= 1'b0;
      end
      else
      begin
         we_prev_q       <= we_n_s;
         tmr_load_q      <= 1'b0;
         erase_start_out <= 1'b0;
         prog_write_out  <= 1'b0;
         // protected while the hold-low pin is asserted
         if (hold_n_s)
         begin
            state_q       <= ST_STARTUP;
            tmr_load_q    <= 1'b1;
            tmr_ms_q      <= OSC_MS[15:0];
            busy_out      <= 1'b0;
            cmd_ready_out <= 1'b0;
            expect_q      <= EXP_NONE;
         end
         else
         begin
            case (state_q)
               ST_STARTUP:
               begin
                  if (tmr_expired && !tmr_load_q)
                  begin
                     state_q    <= ST_SETUP;
                     tmr_load_q <= 1'b1;
                     tmr_ms_q   <= SETUP_MS[15:0];
                  end
               end
               // setup period, then memory read mode
               ST_SETUP:
               begin
                  if (tmr_expired && !tmr_load_q)
                  begin
                     state_q       <= ST_READ;
                     show_q        <= SHOW_MEM;
                     cmd_ready_out <= 1'b1;
                  end
               end
               // erase covers the whole array; minimum duration
               ST_ERASE:
               begin
                  // writes during erase are not decoded
                  if (tmr_expired && !tmr_load_q)
                  begin
                     busy_out <= 1'b0;
                     // done flag set, result by failure
                     poll_q   <= erase_fail_in ? 2'h2 : 2'h3;
                     if (erase_fail_in)
                        status_q <= status_q | 8'h90;
                     state_q  <= ST_WAIT;
                  end
               end
               ST_PROG:
               begin
                  if (wr_pulse)
                  begin
                     prog_write_out <= 1'b1;
                     prog_data_out  <= din_s;
                     if (prog_cnt_q == 8'h0)
                     begin
                        mem_addr_out <= addr_s;
                        // invalid block start address
                        if (addr_s[6:0] != 7'h0)
                           status_q <= status_q | 8'h81;
                     end
                     if (prog_cnt_q == `FWE_PROG_BYTES - 1)
                     begin
                        prog_cnt_q <= 8'h0;
                        busy_out   <= 1'b0;
                        poll_q     <= (prog_fail_in || status_q[0]) ? 2'h2 : 2'h3;
                        if (prog_fail_in)
                           status_q <= status_q | 8'ha0;
                        state_q    <= ST_WAIT;
                     end
                     else
                        prog_cnt_q <= prog_cnt_q + 8'h1;
                  end
               end
               default:
               begin
                  // command wait, memory read and status show accept writes
                  if (wr_pulse)
                  begin
                     // poll flags replaced only by a command write
                     poll_q <= 2'h0;
                     // only a non-status command clears the return code
                     if (din_s != `FWE_CMD_STATUS)
                        status_q <= `FWE_STATUS_RESET;
                     if (expect_q == EXP_ERASE && din_s == `FWE_CMD_ERASE)
                     begin
                        state_q    <= ST_ERASE;
                        show_q     <= SHOW_POLL;
                        busy_out   <= 1'b1;
                        erase_start_out <= 1'b1;
                        tmr_load_q <= 1'b1;
                        tmr_ms_q   <= ERASE_MS[15:0];
                        expect_q   <= EXP_NONE;
                     end
                     else if (expect_q == EXP_STATUS && din_s == `FWE_CMD_STATUS)
                     begin
                        // status byte shown; then command wait
                        state_q  <= ST_WAIT;
                        show_q   <= SHOW_STATUS;
                        expect_q <= EXP_NONE;
                     end
                     else if (din_s == `FWE_CMD_ERASE)
                        expect_q <= EXP_ERASE;
                     else if (din_s == `FWE_CMD_STATUS)
                        expect_q <= EXP_STATUS;
                     else if (din_s == `FWE_CMD_READ)
                     begin
                        state_q  <= ST_READ;
                        show_q   <= SHOW_MEM;
                        expect_q <= EXP_NONE;
                     end
                     else if (din_s == `FWE_CMD_PROGRAM)
                     begin
                        state_q    <= ST_PROG;
                        show_q     <= SHOW_POLL;
                        busy_out   <= 1'b1;
                        prog_cnt_q <= 8'h0;
                        expect_q   <= EXP_NONE;
                     end
                     else
                     begin
                        status_q <= 8'hc0;
                        poll_q   <= 2'h2;
                        show_q   <= SHOW_POLL;
                        expect_q <= EXP_NONE;
                        state_q  <= ST_WAIT;
                     end
                  end
                  if (state_q == ST_READ && rd_active)
                     mem_addr_out <= addr_s;
               end
            endcase
         end
      end
   end

   // data pin drive, registered; memory data outside memory read mode is zero
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flash_data_pins_out    <= 8'h0;
         flash_data_pins_oe_out <= 1'b0;
         mem_read_out           <= 1'b0;
      end
      else
      begin
         // drive only while chip select and output enable are low
         flash_data_pins_oe_out <= rd_active && !hold_n_s;
         mem_read_out <= rd_active && (state_q == ST_READ) && (show_q == SHOW_MEM);
         case (show_q)
            // low six bits zero during polling
            SHOW_POLL:   flash_data_pins_out <= {poll_q, 6'h0};
            // bits 3 and 2 read as zero
            SHOW_STATUS: flash_data_pins_out <= status_q & 8'hf3;
            default:     flash_data_pins_out <= (state_q == ST_READ) ? mem_rdata_in : 8'h0;
         endcase
      end
   end
endmodule

// file: fwe_writer_checker.sv
`timescale 1ns/1ns
// watches the writer pins and the erase handshake from outside the block
module fwe_writer_checker
#(
   parameter OSC_MS      = 20,
   parameter SETUP_MS    = 10,
   parameter ERASE_MS    = 100,
   parameter TICK_CYCLES = 100000
)
(
   input wire       clock_in,
   input wire       rst_n_in,
   input wire       hold_low_input_n_in,
   input wire       chip_sel_n_in,
   input wire       out_en_n_in,
   input wire       write_en_n_in,
   input wire [7:0] flash_data_pins_out,
   input wire       flash_data_pins_oe_out,
   input wire       erase_start_out,
   input wire       prog_write_out,
   input wire       busy_out,
   input wire       cmd_ready_out
);
   localparam integer READY_CYC = (OSC_MS + SETUP_MS) * TICK_CYCLES;
   localparam integer ERASE_CYC = ERASE_MS * TICK_CYCLES;
   reg [31:0] ready_cnt_q;
   reg [31:0] erase_cnt_q;
   reg        erase_run_q;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // cycles since the hold pin went high; a low hold restarts startup
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ready_cnt_q <= 32'h0;
      else if (!hold_low_input_n_in)
         ready_cnt_q <= 32'h0;
      else
         ready_cnt_q <= ready_cnt_q + 32'h1;
   end
   // length of each erase, counted from its start pulse to busy falling
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         erase_run_q <= 1'b0;
      else if (erase_start_out)
         erase_run_q <= 1'b1;
      else if (!busy_out)
         erase_run_q <= 1'b0;
   end
   always @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         erase_cnt_q <= 32'h0;
      else if (erase_start_out)
         erase_cnt_q <= 32'h0;
      else if (erase_run_q)
         erase_cnt_q <= erase_cnt_q + 32'h1;
   end
   a_ready_not_early: assert property ($rose(cmd_ready_out) |-> ready_cnt_q >= READY_CYC)
      else $error("command wait entered before startup and setup ended");
   a_refuse_early: assert property (!cmd_ready_out |-> !erase_start_out && !prog_write_out && !busy_out)
      else $error("operation started before commands were accepted");
   a_erase_one_pulse: assert property (erase_start_out |=> !erase_start_out && busy_out)
      else $error("erase start not a single pulse followed by busy");
   a_erase_min_time: assert property (erase_run_q && !busy_out |-> erase_cnt_q >= ERASE_CYC - 4)
      else $error("erase finished too early");
   a_erase_max_time: assert property (erase_run_q |-> erase_cnt_q <= ERASE_CYC + TICK_CYCLES + 4)
      else $error("erase ran too long");
   a_busy_no_restart: assert property (busy_out && $past(busy_out) |-> !erase_start_out)
      else $error("erase restarted while busy");
   a_poll_running: assert property (busy_out && $past(busy_out) && flash_data_pins_oe_out |-> flash_data_pins_out == 8'h00)
      else $error("running poll value not zero");
   a_pins_release: assert property ((chip_sel_n_in || out_en_n_in) [*5] |-> !flash_data_pins_oe_out)
      else $error("data pins driven without chip and output enable");
   a_pins_drive: assert property ((!chip_sel_n_in && !out_en_n_in && write_en_n_in) [*5] |-> flash_data_pins_oe_out)
      else $error("data pins not driven during a read");
endmodule

// file: fwe_prog_model.sv
`timescale 1ns/1ns
// programmer side: one strobe access at a time, changed at falling edges
module fwe_prog_model
(
   input  wire        clock_in,
   input  wire [7:0]  pins_in,
   output reg         cs_n_out,
   output reg         oe_n_out,
   output reg         we_n_out,
   output reg  [17:0] addr_out,
   output reg  [7:0]  data_out,
   output reg         got_out,
   output reg  [7:0]  got_data_out
);
   initial
   begin
      cs_n_out = 1'b1;
      oe_n_out = 1'b1;
      we_n_out = 1'b1;
      addr_out = 18'h0;
      data_out = 8'h00;
      got_out = 1'b0;
      got_data_out = 8'h00;
   end
   // command write: chip select and write enable low, data held past the rise
   task wr(input [17:0] a, input [7:0] d);
   begin
      @(negedge clock_in);
      addr_out = a;
      data_out = d;
      cs_n_out = 1'b0;
      we_n_out = 1'b0;
      repeat (5) @(negedge clock_in);
      we_n_out = 1'b1;
      repeat (6) @(negedge clock_in);
      cs_n_out = 1'b1;
      data_out = ~d;  // a released bus must not keep showing the last byte
      repeat (6) @(negedge clock_in);
   end
   endtask
   // read: chip select and output enable low long enough for the sync delay
   task rd(input [17:0] a);
   begin
      @(negedge clock_in);
      addr_out = a;
      cs_n_out = 1'b0;
      oe_n_out = 1'b0;
      repeat (8) @(negedge clock_in);
      got_data_out = pins_in;
      got_out = 1'b1;
      @(negedge clock_in);
      got_out = 1'b0;
      cs_n_out = 1'b1;
      oe_n_out = 1'b1;
      repeat (6) @(negedge clock_in);
   end
   endtask
endmodule

// file: fwe_writer_tb.sv
`timescale 1ns/1ns
`include "fwe_defines.vh"
module fwe_writer_tb;
   localparam TICK = 10;
   reg         clock_in;
   reg         rst_n_in;
   reg         hold_n;
   reg  [7:0]  mem_rdata;
   reg         erase_fail;
   reg         prog_fail;
   wire        cs_n;
   wire        oe_n;
   wire        we_n;
   wire [17:0] addr;
   wire [7:0]  wdata;
   wire [7:0]  dout;
   wire        oe;
   wire        busy;
   wire        ready;
   wire        got;
   wire [7:0]  got_data;
   wire [7:0]  bus;
   integer     err_total = 0;
   integer     total_checks = 0;
   integer     cyc = 0;
   integer     i;
   integer     k;
   reg  [7:0]  exp_v;
   reg  [17:0] base;
   reg  [7:0]  exp_q[$];
   reg  [7:0]  pq[$];
   reg  [7:0]  wd;
   reg  [7:0]  pd_exp;
   wire        pw;
   wire [7:0]  pd;
   wire [17:0] ma;
   wire        mr;
   integer     mr_cnt = 0;
   // device drives the shared data pins only while its enable is high
   assign bus = oe ? dout : wdata;
   fwe_writer #(.TICK_CYCLES(TICK)) DUT (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .hold_low_input_n_in(hold_n),
      .chip_sel_n_in(cs_n), .out_en_n_in(oe_n), .write_en_n_in(we_n),
      .flash_addr_pins_in(addr), .flash_data_pins_in(bus), .mem_rdata_in(mem_rdata),
      .erase_fail_in(erase_fail), .prog_fail_in(prog_fail), .flash_data_pins_out(dout),
      .flash_data_pins_oe_out(oe), .mem_addr_out(ma), .mem_read_out(mr), .erase_start_out(),
      .prog_write_out(pw), .prog_data_out(pd), .busy_out(busy), .cmd_ready_out(ready));
   fwe_prog_model PRG (
      .clock_in(clock_in), .pins_in(bus), .cs_n_out(cs_n), .oe_n_out(oe_n), .we_n_out(we_n),
      .addr_out(addr), .data_out(wdata), .got_out(got), .got_data_out(got_data));
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   task summarize;
   begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   // the longest run is about a thousand cycles per erase and over two thousand per program
   always @(posedge clock_in)
   begin
      cyc = cyc + 1;
      if (cyc == 60000)
      begin
         err_total = err_total + 1;
         summarize;
      end
   end
   // every finished read is compared with the oldest noted expectation
   always @(posedge got)
   begin
      exp_v = exp_q.pop_front();
      total_checks = total_checks + 1;
      if (got_data !== exp_v)
      begin
         err_total = err_total + 1;
         $display("BAD %0t read %h expected %h", $time, got_data, exp_v);
      end
   end
   task chk(input [7:0] e, input [17:0] a);
   begin
      exp_q.push_back(e);
      PRG.rd(a);
   end
   endtask
   // side outputs: ok is already a known 0 or 1 from a case compare or an integer equality
   task check_ok(input ok);
   begin
      total_checks = total_checks + 1;
      if (!ok)
      begin
         err_total = err_total + 1;
         $display("BAD %0t side output mismatch", $time);
      end
   end
   endtask
   // each byte handed to the array must be the byte the programmer wrote
   always @(negedge clock_in)
   begin
      if (pw === 1'b1)
      begin
         pd_exp = pq.pop_front();
         total_checks = total_checks + 1;
         if (pd !== pd_exp)
         begin
            err_total = err_total + 1;
            $display("BAD %0t program byte %h expected %h", $time, pd, pd_exp);
         end
      end
   end
   // array reads counted; only memory read mode may raise the strobe
   always @(posedge mr)
      mr_cnt = mr_cnt + 1;
   task stat_cmd;
   begin
      PRG.wr(18'h0, `FWE_CMD_STATUS);
      PRG.wr(18'h0, `FWE_CMD_STATUS);
   end
   endtask
   // erase pair, one millisecond before polling, then a write that must be ignored
   task erase_op;
   begin
      PRG.wr(18'h0, `FWE_CMD_ERASE);
      PRG.wr(18'h0, `FWE_CMD_ERASE);
      repeat (TICK) @(negedge clock_in);
      chk(8'h00, 18'h0);
      PRG.wr(18'h0, `FWE_CMD_READ);
      while (busy === 1'b1) @(negedge clock_in);
   end
   endtask
   initial
   begin
      rst_n_in = 1'b0;
      hold_n = 1'b0;
      mem_rdata = 8'h00;
      erase_fail = 1'b0;
      prog_fail = 1'b0;
      k = $urandom(32'h5604);
      repeat (5) @(posedge clock_in);
      @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (20) @(negedge clock_in);
      hold_n = 1'b1;
      stat_cmd;
      check_ok(ready === 1'b0);
      repeat ((`FWE_OSC_MS + `FWE_SETUP_MS) * TICK) @(negedge clock_in);
      check_ok(ready === 1'b1);
      mem_rdata = 8'($urandom);
      base = 18'($urandom);
      chk(mem_rdata, base);
      check_ok(ma === base);
      PRG.wr(18'h0, 8'($urandom) | 8'h02);
      chk(8'h80, 18'h0);
      stat_cmd;
      chk(8'hc0, 18'h0);
      chk(8'hc0, 18'h0);
      erase_op;
      chk(8'hc0, 18'h0);
      chk(8'hc0, 18'h0);
      stat_cmd;
      chk(8'h00, 18'h0);
      erase_fail = 1'b1;
      erase_op;
      erase_fail = 1'b0;
      chk(8'h80, 18'h0);
      stat_cmd;
      chk(8'h90, 18'h0);
      PRG.wr(18'h0, `FWE_CMD_READ);
      chk(mem_rdata, 18'h0);
      erase_op;
      // each block programmed once since the erase
      for (i = 0; i < 2; i = i + 1)
      begin
         base = (i == 0) ? 18'h00180 : 18'h00201;
         prog_fail = (i == 0);
         PRG.wr(base, `FWE_CMD_PROGRAM);
         for (k = 0; k < `FWE_PROG_BYTES; k = k + 1)
         begin
            wd = 8'($urandom);
            pq.push_back(wd);
            PRG.wr(base + 18'(k), wd);
         end
         while (busy === 1'b1) @(negedge clock_in);
         check_ok(ma === base);
         chk(8'h80, base);
         stat_cmd;
         chk((i == 0) ? 8'ha0 : 8'h81, base);
      end
      check_ok(pq.size() == 0);
      check_ok(mr_cnt == 2);
      summarize;
   end
endmodule
bind fwe_writer fwe_writer_checker #(.OSC_MS(OSC_MS), .SETUP_MS(SETUP_MS),
   .ERASE_MS(ERASE_MS), .TICK_CYCLES(TICK_CYCLES)) CHK (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .hold_low_input_n_in(hold_low_input_n_in),
   .chip_sel_n_in(chip_sel_n_in), .out_en_n_in(out_en_n_in), .write_en_n_in(write_en_n_in),
   .flash_data_pins_out(flash_data_pins_out), .flash_data_pins_oe_out(flash_data_pins_oe_out),
   .erase_start_out(erase_start_out), .prog_write_out(prog_write_out), .busy_out(busy_out),
   .cmd_ready_out(cmd_ready_out));
